// File: rtl/tcr_pkg.sv
// shared constants and types for the thermocouple readout link
package tcr_pkg;
  localparam int CLK_MHZ         = 10;
  // conversion period, split evenly across the three phases
  localparam int CONV_PERIOD_MS  = 70;
  localparam int CONV_PERIOD_CYC = CONV_PERIOD_MS * CLK_MHZ * 1000;
  // straight-line gain in nV per degree, and its reciprocal in
  // quarter degrees per uV, scaled by 2^16
  localparam int GAIN_NV_PER_C   = 41276;
  localparam int GAIN_RECIP_Q16  =
    (4 * 65536 * 1000 + GAIN_NV_PER_C / 2) / GAIN_NV_PER_C;
  localparam int ADC_W           = 20;
  // output word layout
  localparam int WORD_W          = 32;
  localparam int TC_W            = 14;
  localparam int CJ_W            = 12;
  localparam int TC_LSB          = 18;
  localparam int RES_HI_BIT      = 17;
  localparam int FAULT_BIT       = 16;
  localparam int CJ_LSB          = 4;
  localparam int RES_LO_BIT      = 3;
  localparam int SCV_BIT         = 2;
  localparam int SCG_BIT         = 1;
  localparam int OC_BIT          = 0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [13:0] TC_OPEN    = 14'h1fff;
  localparam logic [13:0] TC_SAT_HI  = 14'h1fff;
  localparam logic [13:0] TC_SAT_LO  = 14'h2000;
  // host read lengths
  localparam int BITS_SHORT      = 14;
  localparam int BITS_FULL       = 32;
  // host serial timing
  localparam int SCK_HALF_NS     = 800;
  localparam int SCK_HALF_CYC    = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int CS_IDLE_NS      = 200;
  localparam int CS_IDLE_CYC     = (CS_IDLE_NS * CLK_MHZ + 999) / 1000;
  // host register map
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA   = 8'h08;
  localparam int CTRL_START      = 0;
  localparam int CTRL_FULL       = 1;
  localparam int CTRL_ABORT      = 2;
  localparam int STAT_BUSY       = 0;
  localparam int STAT_DONE       = 1;

  typedef enum logic [1:0] {
    PH_CJ  = 2'b00,
    PH_TC  = 2'b01,
    PH_FLT = 2'b10
  } tcr_phase_e;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_LEAD  = 3'b001,
    HS_HIGH  = 3'b010,
    HS_LOW   = 3'b011,
    HS_TRAIL = 3'b100,
    HS_GAP   = 3'b101
  } tcr_hstate_e;
endpackage : tcr_pkg

// File: rtl/tcr_link_if.sv
// serial link between the converter and its host
`timescale 1ns/1ps
interface tcr_link_if;
  logic cs_n;
  logic sck;
  logic so;
  logic so_oe;
  logic so_line;

  // undriven line reads low, as a weak pull-down would give
  assign so_line = so_oe ? so : 1'b0;

  modport dev (input cs_n, input sck, output so, output so_oe);
  modport host (output cs_n, output sck, input so_line);
endinterface : tcr_link_if

// File: rtl/tcr_dev.sv
// converter end: conversion sequencer, result word and serial output
`timescale 1ns/1ps
module tcr_dev #(
  parameter int CONV_PERIOD_CYC = tcr_pkg::CONV_PERIOD_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  tcr_link_if.dev                lnk,
  input  wire logic [19:0]       i_adc_data,
  input  wire logic              i_short_to_supply,
  input  wire logic              i_short_to_ground,
  input  wire logic              i_open_circuit,
  output logic                   o_fault_path_pos_switch,
  output logic                   o_fault_path_neg_switch,
  output logic                   o_neg_ground_ref_switch,
  output logic                   o_thermo_to_adc_switch,
  output logic                   o_cold_junction_path_switch
);
  localparam int PHASE_CYC = CONV_PERIOD_CYC / 3;
  localparam int PCW       = $clog2(PHASE_CYC + 1);

  typedef struct packed {
    tcr_pkg::tcr_phase_e phase;
    logic [PCW-1:0]      pcnt;
    logic signed [11:0]  cj_raw;
    logic signed [19:0]  tc_uv;
    logic                short_to_supply_flag;
    logic                short_to_ground_flag;
    logic                open_circuit_flag;
    logic [31:0]         word;
    logic                cs_s1;
    logic                cs_s2;
    logic                sck_s1;
    logic                sck_s2;
    logic                sck_s3;
    logic                active;
    logic [31:0]         shreg;
    logic                so;
    logic                so_oe;
  } tcr_dev_s;

  tcr_dev_s r_ff;
  tcr_dev_s nxt_r;

  logic signed [33:0] prod;
  logic signed [17:0] cj_q;
  logic signed [17:0] hot;
  logic [13:0]        tc_field;
  logic               any_fault;
  logic               sck_fall;

  // temperature arithmetic, from the latest completed phase results
  always_comb
  begin
    // uV times reciprocal gain gives quarter degrees, no curve fit
    prod = 34'(r_ff.tc_uv) * 34'(tcr_pkg::GAIN_RECIP_Q16);
    cj_q = 18'(r_ff.cj_raw) >>> 2;
    hot  = 18'(prod >>> 16) + cj_q;
    if (r_ff.open_circuit_flag)
    begin
      tc_field = tcr_pkg::TC_OPEN;
    end
    else if (hot > 18'sd8191)
    begin
      tc_field = tcr_pkg::TC_SAT_HI;
    end
    else if (hot < -18'sd8192)
    begin
      tc_field = tcr_pkg::TC_SAT_LO;
    end
    else
    begin
      tc_field = hot[13:0];
    end
    any_fault = r_ff.short_to_supply_flag | r_ff.short_to_ground_flag
              | r_ff.open_circuit_flag;
  end

  // whole next state
  always_comb
  begin
    nxt_r = r_ff;
    // select passes two flops, sck three; only cs_s2, sck_s2 and sck_s3 are inspected
    nxt_r.cs_s1  = lnk.cs_n;
    nxt_r.cs_s2  = r_ff.cs_s1;
    nxt_r.sck_s1 = lnk.sck;
    nxt_r.sck_s2 = r_ff.sck_s1;
    nxt_r.sck_s3 = r_ff.sck_s2;
    sck_fall     = r_ff.sck_s3 & ~r_ff.sck_s2;

    // free-running sequencer, no host involvement
    nxt_r.pcnt = r_ff.pcnt + 1'b1;
    if (r_ff.pcnt == PCW'(PHASE_CYC - 1))
    begin
      nxt_r.pcnt = '0;
      unique case (r_ff.phase)
        tcr_pkg::PH_CJ:
        begin
          nxt_r.cj_raw = i_adc_data[11:0];
          nxt_r.phase  = tcr_pkg::PH_TC;
        end
        tcr_pkg::PH_TC:
        begin
          nxt_r.tc_uv = i_adc_data;
          nxt_r.phase = tcr_pkg::PH_FLT;
        end
        tcr_pkg::PH_FLT:
        begin
          // flags reflect the latest test, not sticky
          nxt_r.short_to_supply_flag = i_short_to_supply;
          nxt_r.short_to_ground_flag = i_short_to_ground;
          nxt_r.open_circuit_flag    = i_open_circuit;
          nxt_r.phase                = tcr_pkg::PH_CJ;
        end
        default:
        begin
          nxt_r.phase = tcr_pkg::PH_CJ;
        end
      endcase
    end

    // result word tracks results only while the host is not reading
    if (r_ff.cs_s2)
    begin
      nxt_r.word = {tc_field, 1'b0, any_fault, r_ff.cj_raw,
                    1'b0, r_ff.short_to_supply_flag,
                    r_ff.short_to_ground_flag,
                    r_ff.open_circuit_flag};
    end

    // serial output
    if (r_ff.cs_s2)
    begin
      // select high: frame abandoned, line released, clock ignored
      nxt_r.active = 1'b0;
      nxt_r.so_oe  = 1'b0;
      nxt_r.so     = 1'b0;
    end
    else if (!r_ff.active)
    begin
      // select just fell: freeze a copy and show its top bit
      nxt_r.active = 1'b1;
      nxt_r.shreg  = r_ff.word;
      nxt_r.so     = r_ff.word[31];
      nxt_r.so_oe  = 1'b1;
    end
    else if (sck_fall)
    begin
      // past bit 0 the line just shows zeros
      nxt_r.shreg = {r_ff.shreg[30:0], 1'b0};
      nxt_r.so    = r_ff.shreg[30];
    end
  end

  // single state register
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      r_ff <= '{phase: tcr_pkg::PH_CJ, word: tcr_pkg::WORD_RESET,
                cs_s1: 1'b1, cs_s2: 1'b1, default: '0};
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // analog path selects decoded from the phase
  always_comb
  begin
    o_thermo_to_adc_switch      = 1'b0;
    o_cold_junction_path_switch = 1'b0;
    o_neg_ground_ref_switch     = 1'b0;
    o_fault_path_pos_switch     = 1'b0;
    o_fault_path_neg_switch     = 1'b0;
    unique case (r_ff.phase)
      tcr_pkg::PH_CJ:
      begin
        o_cold_junction_path_switch = 1'b1;
        o_neg_ground_ref_switch     = 1'b1;
      end
      tcr_pkg::PH_TC:
      begin
        o_thermo_to_adc_switch  = 1'b1;
        o_neg_ground_ref_switch = 1'b1;
      end
      tcr_pkg::PH_FLT:
      begin
        o_fault_path_pos_switch = 1'b1;
        o_fault_path_neg_switch = 1'b1;
      end
      default:
      begin
        o_neg_ground_ref_switch = 1'b0;
      end
    endcase
  end

  // link outputs straight from flops
  assign lnk.so    = r_ff.so;
  assign lnk.so_oe = r_ff.so_oe;
endmodule : tcr_dev

// File: rtl/tcr_host.sv
// host end: bus-programmed serial reader of the converter word
`timescale 1ns/1ps
module tcr_host #(
  parameter int SCK_HALF_CYC = tcr_pkg::SCK_HALF_CYC,
  parameter int CS_IDLE_CYC  = tcr_pkg::CS_IDLE_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  tcr_link_if.host         lnk,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata
);
  typedef struct packed {
    tcr_pkg::tcr_hstate_e st;
    logic [7:0]           cnt;
    logic [5:0]           bits;
    logic [5:0]           nbits;
    logic                 busy;
    logic                 done;
    logic [31:0]          data;
    logic [31:0]          shreg;
    logic                 cs_n;
    logic                 sck;
    logic                 so_s1;
    logic                 so_s2;
    logic                 a_valid;
    logic                 a_wr;
    logic [7:0]           a_addr;
    logic [31:0]          rdata;
  } tcr_host_s;

  tcr_host_s r_ff;
  tcr_host_s nxt_r;
  logic      start;
  logic      abort;
  logic      half_done;

  always_comb
  begin
    nxt_r       = r_ff;
    nxt_r.so_s1 = lnk.so_line;
    nxt_r.so_s2 = r_ff.so_s1;
    half_done   = r_ff.cnt == 8'(SCK_HALF_CYC - 1);
    nxt_r.cnt   = r_ff.cnt + 8'h01;

    // data phase of a write; size is always a whole word here
    start = r_ff.a_valid & r_ff.a_wr & (r_ff.a_addr == tcr_pkg::OFS_CTRL)
          & i_hwdata[tcr_pkg::CTRL_START];
    abort = r_ff.a_valid & r_ff.a_wr & (r_ff.a_addr == tcr_pkg::OFS_CTRL)
          & i_hwdata[tcr_pkg::CTRL_ABORT];

    // serial engine; bits sampled at the rising sck it makes
    unique case (r_ff.st)
      tcr_pkg::HS_IDLE:
      begin
        nxt_r.cnt = '0;
        if (start)
        begin
          nxt_r.nbits = i_hwdata[tcr_pkg::CTRL_FULL] ?
            6'(tcr_pkg::BITS_FULL) : 6'(tcr_pkg::BITS_SHORT);
          nxt_r.cs_n  = 1'b0;
          nxt_r.bits  = '0;
          nxt_r.shreg = '0;
          nxt_r.busy  = 1'b1;
          nxt_r.done  = 1'b0;
          nxt_r.st    = tcr_pkg::HS_LEAD;
        end
      end
      tcr_pkg::HS_LEAD,
      tcr_pkg::HS_LOW:
      begin
        if (half_done)
        begin
          nxt_r.cnt   = '0;
          nxt_r.sck   = 1'b1;
          nxt_r.shreg = {r_ff.shreg[30:0], r_ff.so_s2};
          nxt_r.bits  = r_ff.bits + 6'h01;
          nxt_r.st    = tcr_pkg::HS_HIGH;
        end
      end
      tcr_pkg::HS_HIGH:
      begin
        if (half_done)
        begin
          nxt_r.cnt = '0;
          nxt_r.sck = 1'b0;
          nxt_r.st  = (r_ff.bits == r_ff.nbits) ? tcr_pkg::HS_TRAIL
                                                : tcr_pkg::HS_LOW;
        end
      end
      tcr_pkg::HS_TRAIL:
      begin
        if (half_done)
        begin
          nxt_r.cnt  = '0;
          nxt_r.cs_n = 1'b1;
          nxt_r.data = r_ff.shreg;
          nxt_r.st   = tcr_pkg::HS_GAP;
        end
      end
      tcr_pkg::HS_GAP:
      begin
        // keeps select high long enough between frames
        if (r_ff.cnt == 8'(CS_IDLE_CYC - 1))
        begin
          nxt_r.busy = 1'b0;
          nxt_r.done = 1'b1;
          nxt_r.st   = tcr_pkg::HS_IDLE;
        end
      end
      default:
      begin
        nxt_r.st = tcr_pkg::HS_IDLE;
      end
    endcase

    // early end: partial word kept, sck parked low
    if (abort && r_ff.busy && r_ff.st != tcr_pkg::HS_GAP)
    begin
      nxt_r.cs_n = 1'b1;
      nxt_r.sck  = 1'b0;
      nxt_r.cnt  = '0;
      nxt_r.data = r_ff.shreg;
      nxt_r.st   = tcr_pkg::HS_GAP;
    end

    // address phase capture; read data from the updated state
    nxt_r.a_valid = i_hsel & i_htrans[1] & i_hready;
    nxt_r.a_wr    = i_hwrite;
    nxt_r.a_addr  = i_haddr[7:0];
    unique case (i_haddr[7:0])
      tcr_pkg::OFS_STATUS: nxt_r.rdata = {30'h0, nxt_r.done, nxt_r.busy};
      tcr_pkg::OFS_DATA:   nxt_r.rdata = nxt_r.data;
      default:             nxt_r.rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      r_ff <= '{st: tcr_pkg::HS_IDLE, cs_n: 1'b1, default: '0};
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // zero-wait slave, always OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = r_ff.rdata;
  assign lnk.cs_n    = r_ff.cs_n;
  assign lnk.sck     = r_ff.sck;
endmodule : tcr_host

// File: sim/tcr_monitor.sv
// concurrent checks on the serial link between host and converter
`timescale 1ns/1ps
module tcr_monitor (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic so,
  input wire logic so_oe
);
  logic [5:0] rises_ff;
  logic       sck_ff;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // rising serial clocks seen in the current frame, cleared while idle
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      rises_ff <= 6'h00;
      sck_ff   <= 1'b0;
    end
    else
    begin
      sck_ff   <= sck;
      rises_ff <= cs_n ? 6'h00 : rises_ff + 6'(sck & ~sck_ff);
    end

  a_oe_on_select: assert property ($fell(cs_n) |-> ##[1:4] so_oe)
    else $error("serial output not enabled after select fall");
  a_oe_off_idle: assert property (cs_n [*5] |-> !so_oe)
    else $error("serial output driven while deselected");
  a_oe_off_rise: assert property ($rose(cs_n) |-> ##[1:4] !so_oe)
    else $error("serial output still driven after select rise");
  a_so_hold_high: assert property (
    so_oe && $past(so_oe) && sck && $past(sck) |-> $stable(so))
    else $error("serial data moved while serial clock high");
  a_sck_rest: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("serial clock active while deselected");
  a_setup_gap: assert property ($fell(cs_n) |-> !sck [*5])
    else $error("serial clock rose too soon after select fall");
  a_sck_high_min: assert property ($rose(sck) |-> sck [*5])
    else $error("serial clock high phase too short");
  a_sck_low_min: assert property ($fell(sck) |-> !sck [*5])
    else $error("serial clock low phase too short");
  a_frame_bits: assert property (rises_ff <= 6'd32)
    else $error("more than a full word clocked in one frame");
endmodule : tcr_monitor

// File: sim/tcr_bench.sv
// self-checking bench: bus host and converter joined over the link
`timescale 1ns/1ps
module tcr_bench;
  logic        i_clk;
  logic        i_nrst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic [19:0] adc_q;
  logic [2:0]  flt_q;
  logic [2:0]  flt_v;
  logic [11:0] die_v;
  logic [19:0] uv_v;
  logic [4:0]  sw;
  logic [31:0] seed;
  logic [31:0] want;
  logic [31:0] got;
  int          errors;
  int          samples_checked;

  tcr_link_if lnk ();
  tcr_link_if lnk_b ();

  tcr_dev #(.CONV_PERIOD_CYC(30)) tcr_dev_inst (
    .i_clk(i_clk), .i_nrst(i_nrst), .lnk(lnk.dev), .i_adc_data(adc_q),
    .i_short_to_supply(flt_q[2]), .i_short_to_ground(flt_q[1]),
    .i_open_circuit(flt_q[0]), .o_fault_path_pos_switch(sw[4]),
    .o_fault_path_neg_switch(sw[3]), .o_neg_ground_ref_switch(sw[2]),
    .o_thermo_to_adc_switch(sw[1]), .o_cold_junction_path_switch(sw[0]));
  // second converter end, its link driven by the bench itself
  tcr_dev #(.CONV_PERIOD_CYC(30)) tcr_dev_b_inst (
    .i_clk(i_clk), .i_nrst(i_nrst), .lnk(lnk_b.dev), .i_adc_data(adc_q),
    .i_short_to_supply(flt_q[2]), .i_short_to_ground(flt_q[1]),
    .i_open_circuit(flt_q[0]), .o_fault_path_pos_switch(),
    .o_fault_path_neg_switch(), .o_neg_ground_ref_switch(),
    .o_thermo_to_adc_switch(), .o_cold_junction_path_switch());
  tcr_host tcr_host_inst (
    .i_clk(i_clk), .i_nrst(i_nrst), .lnk(lnk.host), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata));
  tcr_monitor tcr_monitor_inst (
    .i_clk(i_clk), .i_nrst(i_nrst), .cs_n(lnk.cs_n), .sck(lnk.sck),
    .so(lnk.so), .so_oe(lnk.so_oe));

  // clock
  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;

  // analog stand-in: die code in cold phase, microvolts in thermo phase
  always @(posedge i_clk)
  begin
    adc_q <= sw[1] ? uv_v : {8'h00, die_v};
    flt_q <= flt_v;
  end

  // every phase shows one of the three switch sets, fault set otherwise
  always @(negedge i_clk)
    if (i_nrst)
      chk({27'h0, sw}, (sw == 5'b00101 || sw == 5'b00110) ? {27'h0, sw}
        : 32'h18);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // die codes are multiples of four so the sum needs no rounding
  function automatic logic [31:0] exp_word(input logic [11:0] d,
    input logic [19:0] u, input logic [2:0] f);
    logic [13:0] t;
    int          q;
    // straight-line gain: quarter degrees = uV * 4000 / nV per degree
    q = $signed(u) * 4000 / tcr_pkg::GAIN_NV_PER_C + $signed(d) / 4;
    if (f[0])
      t = 14'h1fff;
    else if (q > 8191)
      t = tcr_pkg::TC_SAT_HI;
    else if (q < -8192)
      t = tcr_pkg::TC_SAT_LO;
    else
      t = q[13:0];
    return {t, 1'b0, |f, d, 1'b0, f};
  endfunction : exp_word

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, g, e);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic give_up();
    errors++;
    $display("unexpected at %0t: wait ran out", $time);
    end_of_test();
  endtask : give_up

  task automatic rdy();
    int k;
    k = 0;
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (hready !== 1'b1 && k < 100);
    if (k >= 100)
      give_up();
  endtask : rdy

  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : ahb

  // start a read of 14 or 32 bits, optionally cut it after some
  // cycles, poll until done, fetch the result
  task automatic host_read(input logic full, input int cut,
    output logic [31:0] d);
    int k;
    ahb(1'b1, tcr_pkg::OFS_CTRL, {30'h0, full, 1'b1}, d);
    if (cut > 0)
    begin
      repeat (cut) @(posedge i_clk);
      ahb(1'b1, tcr_pkg::OFS_CTRL, 32'h1 << tcr_pkg::CTRL_ABORT, d);
    end
    k = 0;
    do
    begin
      ahb(1'b0, tcr_pkg::OFS_STATUS, 32'h0, d);
      k++;
    end
    while (d[tcr_pkg::STAT_DONE] !== 1'b1 && k < 1000);
    if (k >= 1000)
      give_up();
    ahb(1'b0, tcr_pkg::OFS_DATA, 32'h0, d);
  endtask : host_read

  task automatic new_stim(input int it);
    seed  = lfsr(seed);
    die_v = {seed[11:2], 2'b00};
    uv_v  = seed[13] ? 20'h7ffff : seed[12] ? 20'h80000
          : seed[16] ? 20'h02854 : 20'h0;
    flt_v = (it < 3) ? 3'(1 << it) : seed[14] ? seed[17:15] : 3'b000;
    repeat (80) @(posedge i_clk);
  endtask : new_stim

  // bench-made link clock of 800 ns; stray clocks before select
  task automatic frame_b(input int hold, input int n, input logic tog,
    output logic [31:0] w);
    if (tog)
      repeat (3)
      begin
        lnk_b.sck <= 1'b1;
        repeat (4) @(posedge i_clk);
        lnk_b.sck <= 1'b0;
        repeat (4) @(posedge i_clk);
      end
    @(posedge i_clk) lnk_b.cs_n <= 1'b0;
    repeat (10) @(posedge i_clk);
    chk({31'h0, lnk_b.so_oe}, 32'h1);
    w = 32'h0;
    for (int i = 0; i < n; i++)
    begin
      // bit settles three clocks after the fall, read at the fourth
      w = {w[30:0], lnk_b.so_line};
      if (i == hold)
        new_stim(9);
      lnk_b.sck <= 1'b1;
      repeat (4) @(posedge i_clk);
      lnk_b.sck <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
    @(posedge i_clk) lnk_b.cs_n <= 1'b1;
    repeat (10) @(posedge i_clk);
    chk({31'h0, lnk_b.so_oe}, 32'h0);
  endtask : frame_b

  // main sequence
  initial
  begin
    i_nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    adc_q = 20'h0;
    flt_q = 3'b000;
    die_v = 12'h000;
    uv_v = 20'h0;
    flt_v = 3'b000;
    seed = 32'h99534bc9;
    lnk_b.cs_n = 1'b1;
    lnk_b.sck = 1'b0;
    errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    ahb(1'b0, tcr_pkg::OFS_STATUS, 32'h0, got);
    chk(got, 32'h0);
    ahb(1'b0, 8'h40, 32'h0, got);
    chk(got, 32'h0);
    for (int it = 0; it < 8; it++)
    begin
      new_stim(it);
      want = exp_word(die_v, uv_v, flt_v);
      host_read(1'b1, 0, got);
      chk(got, want);
      host_read(1'b0, 0, got);
      chk(got, {18'h0, want[31:18]});
      if (it == 3)
      begin
        frame_b(99, 3, 1'b0, got);
        chk(got, {29'h0, want[31:29]});
        // host cut in the middle of its third low phase, two bits in
        host_read(1'b1, 4 * tcr_pkg::SCK_HALF_CYC
          + tcr_pkg::SCK_HALF_CYC / 2 - 2, got);
        chk(got, {30'h0, want[31:30]});
      end
      frame_b(it == 4 ? 8 : 99, 32, it == 1, got);
      chk(got, want);
      $display("test %0d done", it);
    end
    end_of_test();
  end
endmodule : tcr_bench
